// ==== core/asqc_irq.v ====
`timescale 1ns/1ps
`include "asqc_regs.vh"
`default_nettype none

// gates the queue flags through their enables onto one request
module asqc_irq (
    input wire [7:0] flags, // next queue flag values
    input wire [6:0] enables, // enable bits 14..8 of control
    output wire irq_req // combined request
);

    wire [6:0] gated;

    // enable bit k+8 pairs with flag bit k; any_error has no enable
    genvar i;
    generate
        for (i = 0; i < 7; i = i + 1) begin : g_gate
            assign gated[i] = flags[i] & enables[i]; // R21
        end
    endgenerate

    assign irq_req = |gated; // R21

endmodule

`default_nettype wire

// ==== core/asqc_mem.v ====
`timescale 1ns/1ps
`default_nettype none

// sample storage: one write port, one asynchronous read port
module asqc_mem #(
    parameter WIDTH = 32,
    parameter AW = 8
) (
    input wire clk, // clock
    input wire wr_en, // store strobe
    input wire [AW-1:0] wr_addr, // store address
    input wire [WIDTH-1:0] wr_data, // stored word
    input wire [AW-1:0] rd_addr, // fetch address
    output wire [WIDTH-1:0] rd_data // fetched word
);

    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    // no reset on the array: contents are only read behind a valid count
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];

endmodule

`default_nettype wire

// ==== core/asqc_regs.vh ====
`ifndef ASQC_REGS_VH
`define ASQC_REGS_VH

// register map of the sample queue control block
`define ASQC_ADDR_W 8
`define ASQC_DATA_W 24
`define ASQC_OFF_CTRL 8'h3A
`define ASQC_OFF_FLAGS 8'h3B
`define ASQC_OFF_DATA 8'h3C
`define ASQC_OFF_CMD 8'h3D

// queue_control_register fields
`define ASQC_CTRL_RESET 24'h040200
`define ASQC_CTRL_WMASK 24'h0FFFFF
`define ASQC_BIT_STATUS 19
`define ASQC_BIT_TAG 18
`define ASQC_MODE_HI 17
`define ASQC_MODE_LO 16
`define ASQC_EN_HI 14
`define ASQC_EN_LO 8
`define ASQC_MARK_HI 7
`define ASQC_MARK_LO 0

// buffer_mode_sel encodings
`define ASQC_MODE_OFF 2'h0
`define ASQC_MODE_WMARK 2'h1

// queue_flag_register bit positions
`define ASQC_FL_DRAINED 0
`define ASQC_FL_MARK 1
`define ASQC_FL_LOST 2
`define ASQC_FL_LOWER 3
`define ASQC_FL_UPPER 4
`define ASQC_FL_FETCH 5
`define ASQC_FL_STORE 6
`define ASQC_FL_ANY 7
`define ASQC_FLAGS_RESET 8'h01

// read command register
`define ASQC_CMD_START 0

`endif

// ==== core/asqc_top.v ====
//
// Overview of operation
// R1: with status append set, flag word is sent once before samples per read command.
// R2: with status and tag both set, one status word, then tag before each sample.
// R3: with tag append set (reset 1), tag word precedes each sample word.
// R4: mode 00 at reset disables queue; results go to ordinary data register only.
// R5: mode 01 keeps first N samples, drops newer until stored ones are read.
// R6: in watermark mode reading a sample removes it and frees its entry.
// R7: watermark mode sets lost_sample_flag when a new sample is dropped; a drop during a read command sets only store_fail_flag.
// R8: modes 10/11 keep newest; when full the oldest entry is overwritten; during a read command new samples are dropped instead.
// R9: streaming mode sets lost_sample_flag when an old sample is dropped.
// R10: host always writes zero to reserved control bit 15.
// R11: store_fail_irq_en gates store_fail_flag onto the interrupt.
// R12: fetch_fail_irq_en gates fetch_fail_flag onto the interrupt.
// R13: upper_level_irq_en gates upper_level_flag onto the interrupt.
// R14: lower_level_irq_en gates lower_level_flag onto the interrupt.
// R15: lost_sample_irq_en gates lost_sample_flag onto the interrupt.
// R16: fill_mark_irq_en (reset 1) gates fill_mark_flag onto the interrupt.
// R17: drained_irq_en raises the interrupt in the cycle drained_flag sets.
// R18: fill_mark_level 1..255 is the sample count; 0 means 256.
// R19: store_fail_flag clears when the queue empties; its interrupt follows it.
// R20: any_error_flag and main error output set when any error flag is set.
// R21: interrupt is OR of every flag ANDed with its enable.
//
`timescale 1ns/1ps
`include "asqc_regs.vh"
`default_nettype none

module asqc_top #(
    parameter DW = 24,
    parameter TW = 8,
    parameter AW = 8,
    parameter [8:0] LOWER_LEVEL = 9'h004,
    parameter [8:0] UPPER_LEVEL = 9'h0C0
) (
    input wire ref_clk, // 250 MHz clock
    input wire reset, // async reset, active high
    input wire [`ASQC_ADDR_W-1:0] reg_addr, // register address
    input wire [`ASQC_DATA_W-1:0] reg_wdata, // register write data
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    output reg [`ASQC_DATA_W-1:0] reg_rdata, // read data, cycle after strobe
    input wire conv_valid, // conversion result strobe
    input wire [DW-1:0] conv_data, // conversion result
    input wire [TW-1:0] conv_tag, // per_sample_tag of the result
    output reg [DW-1:0] ord_data_r, // ordinary data register
    output reg ord_valid_r, // pulse: ordinary data updated
    output reg irq_r, // selected interrupt pin request
    output reg main_err_r // error bit of main status
);

    localparam [8:0] DEPTH = 9'h100;
    localparam [AW-1:0] PTR_ONE = {{(AW-1){1'b0}}, 1'b1};
    localparam [8:0] CNT_ONE = 9'h001;

    ////////////////////////////////////////////////////////////////////////
    // registers and decode

    reg [`ASQC_DATA_W-1:0] ctrl_r;
    reg [7:0] flags_r;
    reg [7:0] flags_nxt;
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [8:0] cnt_r;
    reg [8:0] cnt_nxt;
    reg cmd_active_r;
    reg stat_pend_r;
    reg tag_done_r;
    reg wm_lock_r;
    reg [`ASQC_DATA_W-1:0] rdata_nxt;

    wire [1:0] mode = ctrl_r[`ASQC_MODE_HI:`ASQC_MODE_LO];
    wire queue_on = (mode != `ASQC_MODE_OFF); // R4
    wire wmark_mode = (mode == `ASQC_MODE_WMARK);
    wire stream_mode = queue_on && !wmark_mode; // R8
    wire tag_en = ctrl_r[`ASQC_BIT_TAG];
    wire stat_en = ctrl_r[`ASQC_BIT_STATUS];
    wire [7:0] mark_field = ctrl_r[`ASQC_MARK_HI:`ASQC_MARK_LO];
    // zero means the whole queue
    wire [8:0] mark_level = (mark_field == 8'h00) ? DEPTH : {1'b0, mark_field}; // R18

    wire wr_ctrl = reg_wr && (reg_addr == `ASQC_OFF_CTRL);
    wire wr_cmd = reg_wr && (reg_addr == `ASQC_OFF_CMD);
    wire rd_flags = reg_rd && (reg_addr == `ASQC_OFF_FLAGS);
    wire rd_data = reg_rd && (reg_addr == `ASQC_OFF_DATA);

    wire [TW+DW-1:0] mem_rd;
    wire irq_req;

    ////////////////////////////////////////////////////////////////////////
    // queue read command sequencing

    reg give_stat;
    reg give_tag;
    reg give_sample;
    reg fetch_fail;

    always @* begin
        give_stat = 1'b0;
        give_tag = 1'b0;
        give_sample = 1'b0;
        fetch_fail = 1'b0;
        if (rd_data) begin
            if (!cmd_active_r || !queue_on) begin
                fetch_fail = 1'b1;
            end else if (stat_pend_r) begin
                give_stat = 1'b1; // R1
            end else if (cnt_r == 9'h000) begin
                fetch_fail = 1'b1;
            end else if (tag_en && !tag_done_r) begin
                give_tag = 1'b1; // R3
            end else begin
                give_sample = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // store side

    // a read command in progress freezes the queue so tags and samples pair
    wire pop = give_sample; // R6
    wire push_req = conv_valid && queue_on;
    wire queue_full = (cnt_r == DEPTH);
    wire wm_block = wmark_mode && (wm_lock_r || cnt_r >= mark_level); // R5
    wire busy_drop = push_req && cmd_active_r;
    wire wm_drop = push_req && !cmd_active_r && wm_block; // R7
    wire push = push_req && !cmd_active_r && !wm_block;
    wire drop_old = push && stream_mode && queue_full && !pop; // R9
    wire store_fail = busy_drop || wm_drop;

    always @* begin
        cnt_nxt = cnt_r;
        if (push && !pop && !drop_old) begin
            cnt_nxt = cnt_r + CNT_ONE;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - CNT_ONE;
        end
        if (!queue_on) begin
            cnt_nxt = 9'h000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flag update; hardware set wins over every clear while the queue is on

    wire emptied = queue_on && (cnt_nxt == 9'h000);

    always @* begin
        flags_nxt = flags_r;
        if (!queue_on) begin
            flags_nxt = `ASQC_FLAGS_RESET;
        end else begin
            flags_nxt[`ASQC_FL_DRAINED] = emptied;
            flags_nxt[`ASQC_FL_MARK] = (cnt_nxt >= mark_level);
            flags_nxt[`ASQC_FL_LOWER] = (cnt_nxt <= LOWER_LEVEL);
            flags_nxt[`ASQC_FL_UPPER] = (cnt_nxt >= UPPER_LEVEL);
            if (rd_flags) begin
                flags_nxt[`ASQC_FL_LOST] = 1'b0;
                flags_nxt[`ASQC_FL_FETCH] = 1'b0;
            end
            if (emptied) begin
                flags_nxt[`ASQC_FL_STORE] = 1'b0; // R19
            end
            if (wm_drop || drop_old) begin
                flags_nxt[`ASQC_FL_LOST] = 1'b1; // R7 R9
            end
            if (fetch_fail) begin
                flags_nxt[`ASQC_FL_FETCH] = 1'b1;
            end
            if (store_fail) begin
                flags_nxt[`ASQC_FL_STORE] = 1'b1;
            end
        end
        flags_nxt[`ASQC_FL_ANY] = flags_nxt[`ASQC_FL_LOST] | // R20
            flags_nxt[`ASQC_FL_FETCH] | flags_nxt[`ASQC_FL_STORE];
    end

    ////////////////////////////////////////////////////////////////////////
    // read data mux

    always @* begin
        rdata_nxt = {`ASQC_DATA_W{1'b0}};
        if (reg_rd) begin
            if (reg_addr == `ASQC_OFF_CTRL) begin
                rdata_nxt = ctrl_r;
            end else if (reg_addr == `ASQC_OFF_FLAGS) begin
                rdata_nxt = {16'h0000, flags_r};
            end else if (reg_addr == `ASQC_OFF_CMD) begin
                rdata_nxt = {23'h000000, cmd_active_r};
            end else if (give_stat) begin
                rdata_nxt = {16'h0000, flags_r}; // R1 R2
            end else if (give_tag) begin
                rdata_nxt = {{(`ASQC_DATA_W-TW){1'b0}}, mem_rd[TW+DW-1:DW]}; // R2 R3
            end else if (give_sample) begin
                rdata_nxt = mem_rd[DW-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_r <= `ASQC_CTRL_RESET; // R4 R3 R16
            flags_r <= `ASQC_FLAGS_RESET;
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            cnt_r <= 9'h000;
            cmd_active_r <= 1'b0;
            stat_pend_r <= 1'b0;
            tag_done_r <= 1'b0;
            wm_lock_r <= 1'b0;
            reg_rdata <= {`ASQC_DATA_W{1'b0}};
            ord_data_r <= {DW{1'b0}};
            ord_valid_r <= 1'b0;
            irq_r <= 1'b0;
            main_err_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                // bit 15 is stored as written; software keeps it zero
                ctrl_r <= reg_wdata & `ASQC_CTRL_WMASK; // R10
            end
            flags_r <= flags_nxt;
            cnt_r <= cnt_nxt;
            reg_rdata <= rdata_nxt;
            main_err_r <= flags_nxt[`ASQC_FL_ANY]; // R20
            irq_r <= irq_req; // R17
            ord_valid_r <= conv_valid && !queue_on;
            if (conv_valid && !queue_on) begin
                ord_data_r <= conv_data; // R4
            end
            if (!queue_on) begin
                wr_ptr_r <= {AW{1'b0}};
                rd_ptr_r <= {AW{1'b0}};
            end else begin
                if (push) begin
                    wr_ptr_r <= wr_ptr_r + PTR_ONE;
                end
                if (pop || drop_old) begin
                    rd_ptr_r <= rd_ptr_r + PTR_ONE; // R8
                end
            end
            // lock holds from reaching the mark until fully drained
            if (!wmark_mode || cnt_nxt == 9'h000) begin
                wm_lock_r <= 1'b0; // R5
            end else if (cnt_nxt >= mark_level) begin
                wm_lock_r <= 1'b1; // R5
            end
            if (wr_cmd) begin
                cmd_active_r <= reg_wdata[`ASQC_CMD_START] && queue_on;
                stat_pend_r <= reg_wdata[`ASQC_CMD_START] && stat_en; // R1
                tag_done_r <= 1'b0;
            end else if (!queue_on) begin
                cmd_active_r <= 1'b0;
                stat_pend_r <= 1'b0;
                tag_done_r <= 1'b0;
            end else begin
                if (give_stat) begin
                    stat_pend_r <= 1'b0; // R2
                end
                if (give_tag) begin
                    tag_done_r <= 1'b1;
                end
                if (give_sample) begin
                    tag_done_r <= 1'b0; // R2
                    // command ends once the last stored sample is out
                    if (cnt_r == CNT_ONE) begin
                        cmd_active_r <= 1'b0;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage and interrupt gating

    asqc_mem #(
        .WIDTH(TW + DW),
        .AW(AW)
    ) u_mem (
        .clk(ref_clk),
        .wr_en(push),
        .wr_addr(wr_ptr_r),
        .wr_data({conv_tag, conv_data}),
        .rd_addr(rd_ptr_r),
        .rd_data(mem_rd)
    );

    // flags_nxt feeds the gate so the pin moves with the flag register
    asqc_irq u_irq (
        .flags(flags_nxt),
        .enables(ctrl_r[`ASQC_EN_HI:`ASQC_EN_LO]), // R11 R12 R13 R14 R15 R16 R17
        .irq_req(irq_req)
    );

endmodule

`default_nettype wire

// ==== testbench/adc_sample_queue_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_sample_queue_control_test;
    logic ref_clk = 1'b0;
    logic reset = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [23:0] reg_wdata = 24'h000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic go = 1'b0;
    logic [8:0] len = 9'h000;
    logic busy, conv_valid, ord_valid_r, irq_r, main_err_r;
    logic [23:0] conv_data, ord_data_r, reg_rdata;
    logic [7:0] conv_tag;
    int mismatches = 0;
    int check_count = 0;
    int i;
    always #2 ref_clk = ~ref_clk;
    asqc_top uut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_valid(conv_valid), .conv_data(conv_data), .conv_tag(conv_tag),
        .ord_data_r(ord_data_r), .ord_valid_r(ord_valid_r), .irq_r(irq_r),
        .main_err_r(main_err_r));
    asqc_conv_model src (.ref_clk(ref_clk), .reset(reset), .go(go), .len(len),
        .conv_valid(conv_valid), .conv_data(conv_data), .conv_tag(conv_tag), .busy(busy));
    ////////////////////////////////////////
    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [23:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic send(input logic [8:0] n);
        int k;
        @(posedge ref_clk);
        go <= 1'b1;
        len <= n;
        @(posedge ref_clk);
        go <= 1'b0;
        #1;
        for (k = 0; k < 800 && busy !== 1'b0; k++) begin
            @(posedge ref_clk);
            #1;
        end
        if (k == 800) begin
            mismatches++;
            close_out;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        reset = 1'b1;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        rd(8'h3A, 24'h040200);
        rd(8'h3B, 24'h000001);
        rd(8'h3C, 24'h000000);
        rd(8'h40, 24'h000000);
        send(9'h001);
        chk(ord_data_r, 24'hA50000);
        wr(8'h3A, 24'hF47F12);
        rd(8'h3A, 24'h047F12);
        repeat (4) @(posedge ref_clk);
        chk({23'h0, irq_r}, 24'h000001);
        $display("test registers done");
        wr(8'h3A, 24'h0E2010);
        send(9'h003);
        wr(8'h3D, 24'h000001);
        rd(8'h3C, 24'h000008);
        for (i = 0; i < 3; i++) begin
            rd(8'h3C, {16'h0000, 8'(i) ^ 8'h5A});
            rd(8'h3C, 24'hA50000 | 24'(i));
        end
        rd(8'h3C, 24'h000000);
        chk({23'h0, irq_r}, 24'h000001);
        rd(8'h3B, 24'h0000A9);
        $display("test stream read done");
        wr(8'h3A, 24'h020400);
        send(9'h101);
        chk({23'h0, irq_r}, 24'h000001);
        chk({23'h0, main_err_r}, 24'h000001);
        rd(8'h3B, 24'h000096);
        wr(8'h3D, 24'h000001);
        rd(8'h3C, 24'hA50001);
        rd(8'h3B, 24'h000010);
        wr(8'h3D, 24'h000000);
        chk({23'h0, irq_r}, 24'h000000);
        wr(8'h3A, 24'h021000);
        rd(8'h3B, 24'h000010);
        chk({23'h0, irq_r}, 24'h000001);
        wr(8'h3A, 24'h0202FF);
        rd(8'h3B, 24'h000012);
        chk({23'h0, irq_r}, 24'h000001);
        $display("test overrun done");
        wr(8'h3A, 24'h000000);
        wr(8'h3A, 24'h014004);
        send(9'h006);
        chk({23'h0, irq_r}, 24'h000001);
        rd(8'h3B, 24'h0000CE);
        wr(8'h3D, 24'h000001);
        for (i = 0; i < 4; i++) begin
            rd(8'h3C, 24'hA50000 | 24'(i));
        end
        rd(8'h3B, 24'h000009);
        chk({23'h0, irq_r}, 24'h000000);
        send(9'h001);
        wr(8'h3D, 24'h000001);
        rd(8'h3C, 24'hA50000);
        $display("test watermark done");
        close_out;
    end
endmodule
`default_nettype wire

// ==== testbench/asqc_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module asqc_checker #(
    parameter DW = 24,
    parameter TW = 8
) (
    input wire logic ref_clk, // clock
    input wire logic reset, // reset
    input wire logic [7:0] reg_addr, // address
    input wire logic [23:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [23:0] reg_rdata, // read data
    input wire logic conv_valid, // result strobe
    input wire logic [DW-1:0] conv_data, // result
    input wire logic [TW-1:0] conv_tag, // tag
    input wire logic [DW-1:0] ord_data_r, // data register
    input wire logic ord_valid_r, // data pulse
    input wire logic irq_r, // interrupt
    input wire logic main_err_r // main error
);
    logic [23:0] ctl_r;
    logic [1:0] qt_r;
    wire logic off = ctl_r[17:16] == 2'h0;
    // mirror of control; qt_r lets forced flags settle after a mode write
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctl_r <= 24'h040200;
            qt_r <= 2'h0;
        end else if (reg_wr && reg_addr == 8'h3A) begin
            ctl_r <= reg_wdata & 24'h0FFFFF;
            qt_r <= 2'h0;
        end else if (qt_r != 2'h3) begin
            qt_r <= qt_r + 2'h1;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence conv_off_s;
        conv_valid && off;
    endsequence
    ctl_read_a: assert property (reg_rd && reg_addr == 8'h3A |=> reg_rdata == ctl_r)
        else $error("control readback wrong");
    unmapped_zero_a: assert property (
        reg_rd && (reg_addr < 8'h3A || reg_addr > 8'h3D) |=> reg_rdata == 24'h0)
        else $error("unmapped read not zero");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 24'h0)
        else $error("read data not idle");
    off_flags_a: assert property (
        reg_rd && reg_addr == 8'h3B && off && qt_r == 2'h3 |=> reg_rdata == 24'h000001)
        else $error("flags wrong while off");
    off_data_a: assert property (reg_rd && reg_addr == 8'h3C && off |=> reg_rdata == 24'h0)
        else $error("queue data while off");
    ord_copy_a: assert property (conv_off_s |=> ord_valid_r && ord_data_r == $past(conv_data))
        else $error("ordinary data not updated");
    ord_quiet_a: assert property (!(conv_valid && off) |=> !ord_valid_r)
        else $error("ordinary pulse without cause");
    off_irq_a: assert property (off && qt_r == 2'h3 |-> irq_r == ctl_r[8])
        else $error("drained interrupt wrong");
    off_err_a: assert property (off && qt_r == 2'h3 |-> !main_err_r)
        else $error("error bit while off");
    any_err_a: assert property (
        reg_rd && reg_addr == 8'h3B |=> reg_rdata[7] == (reg_rdata[2] | reg_rdata[5] | reg_rdata[6]))
        else $error("any error flag wrong");
endmodule
bind asqc_top asqc_checker #(.DW(DW), .TW(TW)) chk (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_valid(conv_valid), .conv_data(conv_data),
    .conv_tag(conv_tag), .ord_data_r(ord_data_r), .ord_valid_r(ord_valid_r),
    .irq_r(irq_r), .main_err_r(main_err_r));
`default_nettype wire

// ==== testbench/asqc_conv_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// converter side: a burst of results, one every second cycle
module asqc_conv_model (
    input wire logic ref_clk, // clock
    input wire logic reset, // reset
    input wire logic go, // start burst
    input wire logic [8:0] len, // burst length
    output logic conv_valid, // result strobe
    output logic [23:0] conv_data, // result
    output logic [7:0] conv_tag, // tag
    output logic busy // burst running
);
    logic [8:0] left_r;
    logic [8:0] idx_r;
    logic ph_r;
    assign busy = left_r != 9'h000 || conv_valid;
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            left_r <= 9'h000;
            idx_r <= 9'h000;
            ph_r <= 1'b0;
            conv_valid <= 1'b0;
            conv_data <= 24'h000000;
            conv_tag <= 8'h00;
        end else begin
            ph_r <= ~ph_r;
            conv_valid <= ph_r && left_r != 9'h000;
            if (go) begin
                left_r <= len;
                idx_r <= 9'h000;
            end else if (ph_r && left_r != 9'h000) begin
                conv_data <= 24'hA50000 | {15'h0, idx_r};
                conv_tag <= idx_r[7:0] ^ 8'h5A;
                idx_r <= idx_r + 9'h001;
                left_r <= left_r - 9'h001;
            end else begin
                // junk between strobes so a stale word is never taken as good
                conv_data <= ~conv_data;
                conv_tag <= ~conv_tag;
            end
        end
    end
endmodule
`default_nettype wire
